// *** ivs_pkg.sv ***
package ivs_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0] OFS_IE_ONE  = 4'h0;
    localparam logic [3:0] OFS_IE_TWO  = 4'h1;
    localparam logic [3:0] OFS_IFG_ONE = 4'h2;
    localparam logic [3:0] OFS_IFG_TWO = 4'h3;

    localparam int BIT_ACCV_EN = 5;
    localparam int BIT_NMI_EN  = 4;
    localparam int BIT_OSC_EN  = 1;
    localparam int BIT_WDT_EN  = 0;
    localparam int BIT_NMI_F   = 4;
    localparam int BIT_RST_F   = 3;
    localparam int BIT_POR_F   = 2;
    localparam int BIT_OSC_F   = 1;
    localparam int BIT_WDT_F   = 0;

    localparam logic RST_ENABLES = 1'b0;
    localparam logic RST_NMI_F   = 1'b0;
    localparam logic RST_OSC_F   = 1'b1;
    localparam logic RST_POR_F   = 1'b1;
    localparam logic RST_RST_F   = 1'b0;
    localparam logic RST_WDT_F   = 1'b0;

    // ----------------------------------------
    // vectors and priorities
    // ----------------------------------------
    localparam logic [15:0] VEC_BASE    = 16'hFFC0;
    localparam logic [15:0] VEC_TOP     = 16'hFFFF;
    localparam logic [15:0] VEC_RESET   = 16'hFFFE;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [4:0]  PRI_RESET   = 5'h1F;
    localparam logic [4:0]  PRI_NMI     = 5'h1E;
    localparam logic [4:0]  PRI_COMP    = 5'h1B;
    localparam logic [4:0]  PRI_WDT     = 5'h1A;
    localparam logic [4:0]  PRI_TMR0    = 5'h19;
    localparam logic [4:0]  PRI_TMR12   = 5'h18;
    localparam logic [4:0]  PRI_CONV    = 5'h15;
    localparam logic [4:0]  PRI_SERIAL  = 5'h14;
    localparam logic [4:0]  PRI_PORT2   = 5'h13;
    localparam logic [4:0]  PRI_PORT1   = 5'h12;
    localparam int          PRI_UNUSED_TOP = 15;

    // ----------------------------------------
    // implemented fetch ranges
    // ----------------------------------------
    localparam logic [15:0] PERIPH_TOP = 16'h01FF;
    localparam logic [15:0] RAM_LO     = 16'h0200;
    localparam logic [15:0] RAM_HI     = 16'h02FF;
    localparam logic [15:0] INFO_LO    = 16'h1000;
    localparam logic [15:0] INFO_HI    = 16'h10FF;
    localparam logic [15:0] CODE_LO    = 16'hE000;

    typedef enum logic [1:0] {
        ST_BOOT,
        ST_BOOT_WAIT,
        ST_RUN,
        ST_SLEEP
    } ivs_state_t;

endpackage : ivs_pkg

// *** ivs_unit.sv ***
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module ivs_unit
    import ivs_pkg::*;
(
    input  wire  logic        SYS_CLK_I,
    input  wire  logic        NRST_I,
    input  wire  logic [3:0]  ADDR_I,
    input  wire  logic [7:0]  WDATA_I,
    input  wire  logic        WR_I,
    input  wire  logic        RD_I,
    output logic [7:0]        RDATA_O,
    input  wire  logic        GIE_I,
    input  wire  logic        INT_ACK_I,
    input  wire  logic        FETCH_I,
    input  wire  logic [15:0] FETCH_ADDR_I,
    input  wire  logic [15:0] VEC_DATA_I,
    input  wire  logic        RST_NMI_PIN_I,
    input  wire  logic        NMI_SEL_I,
    input  wire  logic        WDT_EXPIRE_I,
    input  wire  logic        WDT_INTERVAL_I,
    input  wire  logic        OSC_FAULT_I,
    input  wire  logic        FLASH_KEY_VIOLATION_I,
    input  wire  logic        FLASH_ACCESS_VIOLATION_FLAG_I,
    input  wire  logic        COMPARATOR_FLAG_I,
    input  wire  logic        TIMER_CHANNEL_ZERO_I,
    input  wire  logic [1:0]  TIMER_CHANNEL_FLAG_I,
    input  wire  logic        TIMER_OVERFLOW_FLAG_I,
    input  wire  logic        CONVERTER_DONE_FLAG_I,
    input  wire  logic        SERIAL_UNIT_FLAG_I,
    input  wire  logic        SERIAL_START_FLAG_I,
    input  wire  logic [7:0]  PORT_TWO_CHANGE_FLAGS_I,
    input  wire  logic [7:0]  PORT_ONE_CHANGE_FLAGS_I,
    output logic              IRQ_O,
    output logic [4:0]        IRQ_PRIO_O,
    output logic              VEC_RD_O,
    output logic [15:0]       VEC_ADDR_O,
    output logic              PC_LOAD_O,
    output logic [15:0]       PC_O,
    output logic              POWER_UP_CLEAR_O,
    output logic              CPU_HALT_O,
    output logic              MCLK_STOP_O,
    output logic              SMCLK_STOP_O,
    output logic              ACLK_STOP_O,
    output logic              DCGEN_STOP_O,
    output logic              XOSC_STOP_O
);
    import ivs_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    ivs_state_t  state_r, state_nxt;
    logic        accv_en_r, nmi_en_r, osc_en_r, wdt_en_r;
    logic        nmi_f_r, rst_f_r, por_f_r, osc_f_r, wdt_f_r;
    logic        pin_s1_r, pin_s2_r, pin_d_r;
    logic [7:0]  rdata_r;
    logic        irq_r;
    logic [4:0]  prio_r;
    logic        vec_rd_r;
    logic [15:0] vec_addr_r;
    logic        vec_pend_r;
    logic        pc_load_r;
    logic [15:0] pc_r;
    logic        pwr_clr_r;
    logic        sleep_r;

    // ----------------------------------------
    // pin synchroniser and edges
    // ----------------------------------------
    // pin is active low in both functions
    wire pin_fall = pin_d_r & ~pin_s2_r;
    wire pin_rst  = pin_fall & ~NMI_SEL_I;
    wire pin_nmi  = pin_fall & NMI_SEL_I;

    // ----------------------------------------
    // reset causes
    // ----------------------------------------
    wire in_ram    = (FETCH_ADDR_I >= RAM_LO) && (FETCH_ADDR_I <= RAM_HI);
    wire in_info   = (FETCH_ADDR_I >= INFO_LO) && (FETCH_ADDR_I <= INFO_HI);
    wire in_code   = FETCH_ADDR_I >= CODE_LO;
    wire bad_fetch = FETCH_I & ~(in_ram | in_info | in_code);
    wire wdt_reset = WDT_EXPIRE_I & ~WDT_INTERVAL_I;
    // all of these restart through the reset vector
    wire reset_cause = pin_rst | wdt_reset | FLASH_KEY_VIOLATION_I | bad_fetch;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    wire wr_ie  = WR_I && (ADDR_I == OFS_IE_ONE);
    wire wr_ifg = WR_I && (ADDR_I == OFS_IFG_ONE);
    wire [7:0] ie_view  = {2'b00, accv_en_r, nmi_en_r, 2'b00, osc_en_r, wdt_en_r};
    wire [7:0] ifg_view = {3'b000, nmi_f_r, rst_f_r, por_f_r, osc_f_r, wdt_f_r};
    // second bytes and holes read zero, nothing stored behind them
    wire [7:0] rd_mux = (ADDR_I == OFS_IE_ONE)  ? ie_view  :
                        (ADDR_I == OFS_IFG_ONE) ? ifg_view : 8'h00;

    // ----------------------------------------
    // request vector
    // ----------------------------------------
    wire nmi_grp = (nmi_f_r & nmi_en_r) | (osc_f_r & osc_en_r)
                 | (FLASH_ACCESS_VIOLATION_FLAG_I & accv_en_r);
    wire wdt_irq = wdt_f_r & wdt_en_r & WDT_INTERVAL_I;
    wire tmr12   = |TIMER_CHANNEL_FLAG_I | TIMER_OVERFLOW_FLAG_I;
    wire serial  = SERIAL_UNIT_FLAG_I | SERIAL_START_FLAG_I;

    wire  [31:0] mask_req;
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_req
            if (gi <= PRI_UNUSED_TOP) begin : g_none
                assign mask_req[gi] = 1'b0;
            end else begin : g_src
                assign mask_req[gi] =
                    (gi == int'(PRI_COMP))   ? COMPARATOR_FLAG_I :
                    (gi == int'(PRI_WDT))    ? wdt_irq :
                    (gi == int'(PRI_TMR0))   ? TIMER_CHANNEL_ZERO_I :
                    (gi == int'(PRI_TMR12))  ? tmr12 :
                    (gi == int'(PRI_CONV))   ? CONVERTER_DONE_FLAG_I :
                    (gi == int'(PRI_SERIAL)) ? serial :
                    (gi == int'(PRI_PORT2))  ? |PORT_TWO_CHANGE_FLAGS_I :
                    (gi == int'(PRI_PORT1))  ? |PORT_ONE_CHANGE_FLAGS_I : 1'b0;
            end
        end
    endgenerate

    // maskable sources only count while the global enable is set
    wire [31:0] all_req = {1'b0, nmi_grp, 30'h0} | (GIE_I ? mask_req : 32'h0);

    function automatic logic [4:0] top_prio(input logic [31:0] r);
        logic [4:0] p;
        p = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (r[i]) begin
                p = i[4:0];
            end
        end
        return p;
    endfunction : top_prio

    wire [4:0]  win_prio = top_prio(all_req);
    wire        any_req  = |all_req;
    wire [15:0] prio_vec = VEC_BASE | {10'h000, prio_r, 1'b0};
    wire        take     = INT_ACK_I & irq_r & (state_r == ST_RUN);
    wire        take_nmi = take & (prio_r == PRI_NMI);
    wire        take_wdt = take & (prio_r == PRI_WDT);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_BOOT:      state_nxt = ST_BOOT_WAIT;
            ST_BOOT_WAIT: state_nxt = (VEC_DATA_I == ERASED_WORD) ? ST_SLEEP : ST_RUN;
            ST_RUN:       state_nxt = ST_RUN;
            ST_SLEEP:     state_nxt = ST_SLEEP;
        endcase
        if (reset_cause) begin
            state_nxt = ST_BOOT;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
            pin_d_r  <= 1'b1;
        end else begin
            pin_s1_r <= RST_NMI_PIN_I;
            pin_s2_r <= pin_s1_r;
            pin_d_r  <= pin_s2_r;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_r <= ST_BOOT;
            pwr_clr_r <= 1'b0;
            sleep_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pwr_clr_r <= reset_cause;
            sleep_r <= (state_nxt == ST_SLEEP);
        end
    end

    // ----------------------------------------
    // vector fetch
    // ----------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            irq_r      <= 1'b0;
            prio_r     <= 5'h00;
            vec_rd_r   <= 1'b0;
            vec_addr_r <= 16'h0000;
            vec_pend_r <= 1'b0;
            pc_load_r  <= 1'b0;
            pc_r       <= 16'h0000;
        end else begin
            irq_r      <= any_req & (state_nxt == ST_RUN) & ~take;
            prio_r     <= win_prio;
            vec_rd_r   <= (state_r == ST_BOOT) | take;
            vec_addr_r <= (state_r == ST_BOOT) ? VEC_RESET : prio_vec;
            vec_pend_r <= take;
            pc_load_r  <= ((state_r == ST_BOOT_WAIT) | vec_pend_r) & ~reset_cause;
            if ((state_r == ST_BOOT_WAIT) | vec_pend_r) begin
                pc_r <= VEC_DATA_I;
            end
        end
    end

    // ----------------------------------------
    // enable byte
    // ----------------------------------------
    // acceptance of the shared NMI vector disarms its enables
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            accv_en_r <= RST_ENABLES;
            nmi_en_r  <= RST_ENABLES;
            osc_en_r  <= RST_ENABLES;
            wdt_en_r  <= RST_ENABLES;
        end else if (reset_cause) begin
            accv_en_r <= RST_ENABLES;
            nmi_en_r  <= RST_ENABLES;
            osc_en_r  <= RST_ENABLES;
            wdt_en_r  <= RST_ENABLES;
        end else if (take_nmi) begin
            accv_en_r <= 1'b0;
            nmi_en_r  <= 1'b0;
            osc_en_r  <= 1'b0;
        end else if (wr_ie) begin
            accv_en_r <= WDATA_I[BIT_ACCV_EN];
            nmi_en_r  <= WDATA_I[BIT_NMI_EN];
            osc_en_r  <= WDATA_I[BIT_OSC_EN];
            wdt_en_r  <= WDATA_I[BIT_WDT_EN];
        end
    end

    // ----------------------------------------
    // flag byte, set wins over clear
    // ----------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            nmi_f_r <= RST_NMI_F;
            osc_f_r <= RST_OSC_F;
        end else if (reset_cause) begin
            nmi_f_r <= RST_NMI_F;
            osc_f_r <= RST_OSC_F;
        end else begin
            nmi_f_r <= pin_nmi | (wr_ifg ? WDATA_I[BIT_NMI_F] : nmi_f_r);
            osc_f_r <= OSC_FAULT_I | (wr_ifg ? WDATA_I[BIT_OSC_F] : osc_f_r);
        end
    end

    // only power-on loads reset values here; other resets do not clear them, though a pin reset sets rst_f_r and watchdog expiry sets wdt_f_r
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            por_f_r <= RST_POR_F;
            rst_f_r <= RST_RST_F;
            wdt_f_r <= RST_WDT_F;
        end else begin
            por_f_r <= wr_ifg ? WDATA_I[BIT_POR_F] : por_f_r;
            rst_f_r <= pin_rst | (wr_ifg ? WDATA_I[BIT_RST_F] : rst_f_r);
            wdt_f_r <= WDT_EXPIRE_I
                     | (take_wdt ? 1'b0 : (wr_ifg ? WDATA_I[BIT_WDT_F] : wdt_f_r));
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= RD_I ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign RDATA_O          = rdata_r;
    assign IRQ_O            = irq_r;
    assign IRQ_PRIO_O       = prio_r;
    assign VEC_RD_O         = vec_rd_r;
    assign VEC_ADDR_O       = vec_addr_r;
    assign PC_LOAD_O        = pc_load_r;
    assign PC_O             = pc_r;
    assign POWER_UP_CLEAR_O = pwr_clr_r;
    // one flop feeds every stop line so they never disagree
    assign CPU_HALT_O       = sleep_r;
    assign MCLK_STOP_O      = sleep_r;
    assign SMCLK_STOP_O     = sleep_r;
    assign ACLK_STOP_O      = sleep_r;
    assign DCGEN_STOP_O     = sleep_r;
    assign XOSC_STOP_O      = sleep_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_boot_read;
        VEC_RD_O && (VEC_ADDR_O == VEC_RESET);
    endsequence

    sequence s_erased_word;
        (state_r == ST_BOOT_WAIT) && (VEC_DATA_I == ERASED_WORD) && !reset_cause;
    endsequence

    a_vec_range: assert property (VEC_RD_O |-> VEC_ADDR_O >= VEC_BASE)
        else $error("vector address below vector table");
    a_pc_load_word: assert property (vec_pend_r && !reset_cause |=> PC_LOAD_O && PC_O == $past(VEC_DATA_I))
        else $error("vector word not loaded");
    a_erased_sleep: assert property (s_erased_word |=> CPU_HALT_O && XOSC_STOP_O)
        else $error("erased reset vector did not sleep");
    a_reset_refetch: assert property (reset_cause |=> POWER_UP_CLEAR_O ##1 s_boot_read)
        else $error("reset did not fetch reset vector");
    a_nmi_no_gie: assert property (nmi_grp && state_r == ST_RUN && !reset_cause && !take |=> IRQ_O && IRQ_PRIO_O == PRI_NMI)
        else $error("nmi group blocked");
    a_gie_blocks: assert property (!GIE_I && !nmi_grp |=> !IRQ_O)
        else $error("maskable request passed without enable");
    a_bad_fetch: assert property (FETCH_I && FETCH_ADDR_I <= PERIPH_TOP |=> POWER_UP_CLEAR_O)
        else $error("fetch from register space no reset");
    a_unused_zero: assert property (RD_I && (ADDR_I == OFS_IE_TWO || ADDR_I == OFS_IFG_TWO) |=> RDATA_O == 8'h00)
        else $error("reserved byte not zero");
    a_wdt_mode: assert property (!WDT_INTERVAL_I |-> !wdt_irq)
        else $error("watchdog irq in reset mode");
    a_por_keep: assert property (reset_cause && !wr_ifg |=> por_f_r == $past(por_f_r))
        else $error("power-on flag changed by soft reset");
    a_osc_clear: assert property (reset_cause |=> osc_f_r && !nmi_en_r && !wdt_en_r)
        else $error("clear values not applied");
    a_nmi_pin: assert property (pin_nmi && !reset_cause |=> nmi_f_r)
        else $error("nmi flag not set");

    // ----------------------------------------
    // handshake, sleep and register checks
    // ----------------------------------------
    sequence s_clean_take;
        take && !reset_cause ##1 !reset_cause;
    endsequence

    sequence s_rd_ie;
        RD_I && (ADDR_I == OFS_IE_ONE);
    endsequence

    sequence s_rd_ifg;
        RD_I && (ADDR_I == OFS_IFG_ONE);
    endsequence

    a_take_fetch: assert property (take && !reset_cause |=> VEC_RD_O && !IRQ_O)
        else $error("accepted request not fetched");
    a_vec_load: assert property (s_clean_take |=> PC_LOAD_O)
        else $error("vector word not handed over");
    a_irq_run: assert property (IRQ_O |-> state_r == ST_RUN)
        else $error("request raised outside run state");
    a_prio_range: assert property (IRQ_O |-> IRQ_PRIO_O > PRI_UNUSED_TOP)
        else $error("request on an unused vector");
    a_clear_pulse: assert property (!reset_cause |=> !POWER_UP_CLEAR_O)
        else $error("clear pulse without a cause");
    a_sleep_holds: assert property (CPU_HALT_O && !reset_cause |=> CPU_HALT_O)
        else $error("left deepest sleep without reset");
    a_clk_stops: assert property (CPU_HALT_O |-> MCLK_STOP_O && SMCLK_STOP_O)
        else $error("system clocks run in deepest sleep");
    a_osc_stops: assert property (CPU_HALT_O |-> ACLK_STOP_O && DCGEN_STOP_O)
        else $error("aux clock or dc generator runs in sleep");
    a_rd_idle: assert property (!RD_I |=> RDATA_O == 8'h00)
        else $error("read data without a read");
    a_ie_holes: assert property (s_rd_ie |=> (RDATA_O & 8'hCC) == 8'h00)
        else $error("absent enable bit reads one");
    a_ifg_holes: assert property (s_rd_ifg |=> (RDATA_O & 8'hE0) == 8'h00)
        else $error("absent flag bit reads one");
    a_osc_set: assert property (OSC_FAULT_I |=> osc_f_r)
        else $error("oscillator fault not flagged");
    a_pin_reset: assert property (pin_rst |=> rst_f_r)
        else $error("pin reset not flagged");
    a_wdt_clear: assert property (take_wdt && !WDT_EXPIRE_I |=> !wdt_f_r)
        else $error("watchdog flag kept after acceptance");

endmodule : ivs_unit

`default_nettype wire

// *** ivs_cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module ivs_cpu_model (
    input  wire  logic        clk_i,
    input  wire  logic        nrst_i,
    input  wire  logic        erased_i,
    input  wire  logic        slow_i,
    input  wire  logic        irq_i,
    input  wire  logic        vec_rd_i,
    input  wire  logic [15:0] vec_addr_i,
    output logic              ack_o,
    output logic [15:0]       vec_data_o
);
    // ----------------------------------------
    // vector memory and acceptance
    // ----------------------------------------
    logic [2:0]  wait_r;
    logic [15:0] stale_r;

    // word answers while the read stands, since the unit samples it at the edge ending it;
    // toggling otherwise so stale use shows
    assign vec_data_o = !vec_rd_i ? stale_r :
                        (erased_i && vec_addr_i == 16'hFFFE) ? 16'hFFFF :
                        vec_addr_i ^ 16'h3C00;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_o   <= 1'b0;
            wait_r  <= 3'h0;
            stale_r <= 16'hA5A5;
        end else begin
            stale_r <= ~stale_r;
            // slow mode lets a request stand a few cycles before acceptance
            ack_o  <= irq_i && !ack_o && wait_r == (slow_i ? 3'h4 : 3'h0);
            wait_r <= (!irq_i || ack_o) ? 3'h0 : wait_r + 3'h1;
        end
    end

endmodule : ivs_cpu_model

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top;

    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, gie = 1'b0, fetch = 1'b0;
    logic        pin = 1'b1, nmi_sel = 1'b0, wdt_exp = 1'b0, wdt_int = 1'b0, osc = 1'b0;
    logic        key = 1'b0, accv = 1'b0, erased = 1'b0, slow = 1'b0, clear_seen = 1'b0;
    logic        ack, irq, vec_rd, pc_load, pu_clear;
    logic [4:0]  prio, prio_seen;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [9:0]  src = 10'h000;
    logic [15:0] fetch_addr = 16'hE000, vec_data, vec_addr, pc;
    logic [5:0]  sleep;
    int          n_errors = 0, num_checks = 0, k;
    int          pri_tab [10] = '{27, 25, 24, 24, 24, 21, 20, 20, 19, 18};
    logic [7:0]  nmi_en [3] = '{8'h10, 8'h02, 8'h20};
    logic [7:0]  nmi_flags [3] = '{8'h10, 8'h12, 8'h12};
    logic [7:0]  rst_flags [5] = '{8'h02, 8'h02, 8'h02, 8'h03, 8'h0A};

    always #12.5 clk = ~clk;

    ivs_unit uut (
        .SYS_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .GIE_I(gie), .INT_ACK_I(ack), .FETCH_I(fetch),
        .FETCH_ADDR_I(fetch_addr), .VEC_DATA_I(vec_data), .RST_NMI_PIN_I(pin),
        .NMI_SEL_I(nmi_sel), .WDT_EXPIRE_I(wdt_exp), .WDT_INTERVAL_I(wdt_int),
        .OSC_FAULT_I(osc), .FLASH_KEY_VIOLATION_I(key), .FLASH_ACCESS_VIOLATION_FLAG_I(accv),
        .COMPARATOR_FLAG_I(src[0]), .TIMER_CHANNEL_ZERO_I(src[1]),
        .TIMER_CHANNEL_FLAG_I(src[3:2]), .TIMER_OVERFLOW_FLAG_I(src[4]),
        .CONVERTER_DONE_FLAG_I(src[5]), .SERIAL_UNIT_FLAG_I(src[6]),
        .SERIAL_START_FLAG_I(src[7]), .PORT_TWO_CHANGE_FLAGS_I({src[8], 7'h00}),
        .PORT_ONE_CHANGE_FLAGS_I({7'h00, src[9]}), .IRQ_O(irq), .IRQ_PRIO_O(prio),
        .VEC_RD_O(vec_rd), .VEC_ADDR_O(vec_addr), .PC_LOAD_O(pc_load), .PC_O(pc),
        .POWER_UP_CLEAR_O(pu_clear), .CPU_HALT_O(sleep[5]), .MCLK_STOP_O(sleep[4]),
        .SMCLK_STOP_O(sleep[3]), .ACLK_STOP_O(sleep[2]), .DCGEN_STOP_O(sleep[1]),
        .XOSC_STOP_O(sleep[0])
    );

    ivs_cpu_model cpu (
        .clk_i(clk), .nrst_i(nrst), .erased_i(erased), .slow_i(slow), .irq_i(irq),
        .vec_rd_i(vec_rd), .vec_addr_i(vec_addr), .ack_o(ack), .vec_data_o(vec_data)
    );

    // ----------------------------------------
    // bus cycles and comparison
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check({8'h00, rdata}, {8'h00, exp});
    endtask : rd_chk

    // stale load pulse at entry is skipped, so back-to-back calls stay apart
    task automatic wait_pc(input logic [15:0] v);
        logic [15:0] seen;
        int          i;
        seen       = 16'h0000;
        clear_seen = 1'b0;
        prio_seen  = 5'h00;
        for (i = 0; i < 60; i++) begin
            #1;
            if (vec_rd === 1'b1) seen = vec_addr;
            if (irq === 1'b1) prio_seen = prio;
            if (pu_clear === 1'b1) clear_seen = 1'b1;
            if (pc_load === 1'b1 && i > 0) break;
            @(posedge clk);
        end
        if (i == 60) begin
            n_errors++;
            print_verdict();
        end
        check(seen, v);
        check(pc, (erased && v == 16'hFFFE) ? 16'hFFFF : v ^ 16'h3C00);
    endtask : wait_pc

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        wait_pc(16'hFFFE);
        rd_chk(4'h0, 8'h00);
        rd_chk(4'h2, 8'h06);
        wr_reg(4'h2, 8'h00);
        wr_reg(4'h0, 8'hFF);
        wr_reg(4'h1, 8'hFF);
        rd_chk(4'h0, 8'h33);
        rd_chk(4'h1, 8'h00);
        rd_chk(4'h9, 8'h00);
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h2, 8'hFF);
        rd_chk(4'h2, 8'h1F);
        wr_reg(4'h2, 8'h00);
        src <= 10'h002;
        repeat (10) @(posedge clk);
        #1 check({15'h0000, irq}, 16'h0000);
        @(posedge clk);
        gie   <= 1'b1;
        slow  <= 1'b1;
        fetch <= 1'b1;
        src   <= 10'h000;
        for (k = 0; k < 10; k++) begin
            @(posedge clk);
            src        <= 10'(1 << k);
            fetch_addr <= k[0] ? 16'h02FF : 16'h1000;
            wait_pc(16'hFFC0 + 16'(2 * pri_tab[k]));
            check({11'h000, prio_seen}, 16'(pri_tab[k]));
            @(posedge clk);
            src <= 10'h000;
            repeat (8) @(posedge clk);
        end
        src <= 10'h203;
        wait_pc(16'hFFF6);
        @(posedge clk);
        src <= 10'h202;
        wait_pc(16'hFFF2);
        @(posedge clk);
        src <= 10'h200;
        wait_pc(16'hFFE4);
        @(posedge clk);
        src     <= 10'h000;
        wdt_int <= 1'b1;
        wr_reg(4'h0, 8'h01);
        wdt_exp <= 1'b1;
        @(posedge clk);
        wdt_exp <= 1'b0;
        wait_pc(16'hFFF4);
        check({11'h000, prio_seen}, 16'h001A);
        rd_chk(4'h2, 8'h00);
        @(posedge clk);
        gie     <= 1'b0;
        slow    <= 1'b0;
        wdt_int <= 1'b0;
        nmi_sel <= 1'b1;
        for (k = 0; k < 3; k++) begin
            wr_reg(4'h0, nmi_en[k]);
            pin  <= (k != 0);
            osc  <= (k == 1);
            accv <= (k == 2);
            wait_pc(16'hFFFC);
            check({11'h000, prio_seen}, 16'h001E);
            @(posedge clk);
            pin  <= 1'b1;
            osc  <= 1'b0;
            accv <= 1'b0;
            rd_chk(4'h0, 8'h00);
            rd_chk(4'h2, nmi_flags[k]);
            #1 check({15'h0000, irq}, 16'h0000);
        end
        @(posedge clk);
        nmi_sel <= 1'b0;
        for (k = 0; k < 5; k++) begin
            wr_reg(4'h2, 8'h00);
            wr_reg(4'h0, 8'h33);
            fetch      <= (k < 2);
            fetch_addr <= (k == 0) ? 16'h01FF : 16'h0300;
            key        <= (k == 2);
            wdt_exp    <= (k == 3);
            pin        <= (k != 4);
            @(posedge clk);
            fetch   <= 1'b0;
            key     <= 1'b0;
            wdt_exp <= 1'b0;
            pin     <= 1'b1;
            wait_pc(16'hFFFE);
            check({15'h0000, clear_seen}, 16'h0001);
            rd_chk(4'h0, 8'h00);
            rd_chk(4'h2, rst_flags[k]);
        end
        @(posedge clk);
        erased <= 1'b1;
        nrst   <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        wait_pc(16'hFFFE);
        repeat (3) @(posedge clk);
        #1 check({10'h000, sleep}, 16'h003F);
        print_verdict();
    end

endmodule : tb_top

`default_nettype wire
